// >>> core/standby_pkg.sv
// constants, register map and state encoding for the standby and timer-output block
package standby_pkg;
  // clock and derived timing
  localparam int CLK_MHZ = 40;
  localparam int CLK_PERIOD_NS = 25;
  localparam int INSTR_FX_CYCLES = 64;
  localparam int INSTR_FX_CYCLES_SLOW = 128;
  localparam logic [6:0] TICK_LAST_FAST = 7'(INSTR_FX_CYCLES - 1);
  localparam logic [6:0] TICK_LAST_SLOW = 7'(INSTR_FX_CYCLES_SLOW - 1);
  localparam int STOP_WAIT_US = 10;
  localparam int STOP_WAIT_CYC = STOP_WAIT_US * 1000 / CLK_PERIOD_NS;
  localparam logic [11:0] STOP_WAIT_LOAD = 12'(STOP_WAIT_CYC - 1);

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIMER = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // control register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_EXEC_BIT = 8;
  localparam int CTRL_FLAGCLR_BIT = 9;
  // config register fields
  localparam int CFG_CARMODE_LSB = 0;
  localparam int CFG_CAROFF_BIT = 2;
  localparam int CFG_DIV_BIT = 3;
  localparam int CFG_S0IN_BIT = 4;
  localparam int CFG_LEDMODE_BIT = 5;
  localparam int CFG_SCANVAL_LSB = 8;
  localparam int CFG_SCANOUT_BIT = 16;
  localparam logic [31:0] CFG_RESET = 32'h0001_FF23;
  localparam int TMR_T9_BIT = 9;

  // operand low bits
  localparam logic [2:0] OPL_STOP_A = 3'h0;
  localparam logic [2:0] OPL_STOP_B = 3'h3;
  localparam logic [2:0] OPL_STOP_K0 = 3'h6;
  localparam logic [2:0] OPL_HALT = 3'h5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_PEND = 5'h02,
    ST_STOP = 5'h04,
    ST_WAIT = 5'h08,
    ST_HALT = 5'h10
  } sb_state_t;
endpackage

// >>> core/standby_halt_control.sv
// standby sequencer, down timer and infrared output with an AXI4-Lite register slave
`timescale 1ns/1ps
module standby_halt_control import standby_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] key_input_pins,
  output logic [7:0] scan_drive_pins_o,
  output logic [7:0] scan_drive_pins_oe,
  input wire logic sense0_pin,
  input wire logic sense1_indicator_pin_i,
  output logic sense1_indicator_pin_o,
  output logic sense1_indicator_pin_oe,
  output logic ir_drive_pin,
  output logic osc_in_pin,
  output logic osc_out_pin,
  output logic cpu_halt,
  output logic core_reset_pulse,
  output logic wake_pulse
);

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // carrier period and high width in clocks, doubled by the divider select
  function automatic logic [8:0] car_len(input logic [1:0] mode, input logic div, input logic hi);
    logic [8:0] base;
    case (mode)
      2'h0: base = hi ? 9'h004 : 9'h008;
      2'h1: base = hi ? 9'h020 : 9'h040;
      2'h2: base = hi ? 9'h030 : 9'h060;
      default: base = hi ? 9'h020 : 9'h060;
    endcase
    return div ? {base[7:0], 1'b0} : base;
  endfunction

  // axi slave state
  logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_en;
  // block state
  sb_state_t state_q;
  logic flag_q;
  logic [3:0] op_q;
  logic [11:0] wait_q;
  logic [31:0] cfg_q;
  logic [8:0] count_q;
  logic t9_q, ir_hold_q, car_tail_q;
  logic [6:0] tick_q;
  logic [8:0] car_q;
  logic [3:0] key_m_q, key_s_q;
  logic s0_m_q, s0_s_q, s1_m_q, s1_s_q;
  logic ir_q, led_q, osc_run_q, halt_q, rst_pulse_q, wake_q;

  logic tick, running, key_any, sense_any, cond_now, ctrl_wr, tmr_wr;
  logic exec, legal, pre_ok, is_stop, new_cond, car_high;
  logic [31:0] wmix;

  assign wr_en = aw_have_q && w_have_q && !bvalid_q;
  assign wmix = wmerge(32'h0000_0000, wdata_q, wstrb_q);
  assign ctrl_wr = wr_en && (awaddr_q == OFS_CTRL);
  assign tmr_wr = wr_en && (awaddr_q == OFS_TIMER) && (state_q == ST_RUN);
  assign exec = ctrl_wr && wmix[CTRL_EXEC_BIT] && (state_q == ST_RUN);

  // write address and data taken in either order, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_en) begin
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr_q[1:0] == 2'h0 && awaddr_q <= OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // reads answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      case (s_axi_araddr)
        OFS_CTRL: rdata_q <= {28'h0000000, op_q};
        OFS_TIMER: rdata_q <= {22'h000000, t9_q, count_q};
        OFS_CONFIG: rdata_q <= cfg_q;
        OFS_STATUS: rdata_q <= {20'h00000, key_s_q, s1_s_q, s0_s_q, state_q, flag_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // pin inputs pass two flops before anything reads them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_m_q <= 4'h0;
      key_s_q <= 4'h0;
      s0_m_q <= 1'b0;
      s0_s_q <= 1'b0;
      s1_m_q <= 1'b0;
      s1_s_q <= 1'b0;
    end else begin
      key_m_q <= key_input_pins;
      key_s_q <= key_m_q;
      s0_m_q <= sense0_pin;
      s0_s_q <= s0_m_q;
      s1_m_q <= sense1_indicator_pin_i;
      s1_s_q <= s1_m_q;
    end
  end

  // port and carrier configuration, kept as is through standby
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= CFG_RESET;
    end else if (wr_en && awaddr_q == OFS_CONFIG && state_q == ST_RUN) begin
      cfg_q <= wmerge(cfg_q, wdata_q, wstrb_q) & 32'h0001_FF3F;
    end
  end

  // release condition and setup precondition decode
  assign key_any = |key_s_q;
  assign sense_any = (s0_s_q && cfg_q[CFG_S0IN_BIT]) || (s1_s_q && !cfg_q[CFG_LEDMODE_BIT]);
  assign running = (count_q != 9'h000);
  always_comb begin
    logic [3:0] op;
    op = wmix[CTRL_OP_LSB +: 4];
    is_stop = (op[2:0] != OPL_HALT);
    legal = 1'b1;
    pre_ok = 1'b1;
    case (op[2:0])
      OPL_STOP_A, OPL_STOP_B: pre_ok = cfg_q[CFG_SCANOUT_BIT] &&
                                        (cfg_q[CFG_SCANVAL_LSB +: 8] == 8'hFF);
      OPL_STOP_K0: pre_ok = cfg_q[CFG_SCANOUT_BIT] && cfg_q[CFG_SCANVAL_LSB];
      OPL_HALT: pre_ok = 1'b1;
      default: legal = 1'b0;
    endcase
    // condition for the operand being executed now
    new_cond = is_stop ? (key_any || (op[3] && sense_any)) : !running;
  end
  // condition for the operand already held in standby
  assign cond_now = (op_q[2:0] == OPL_HALT) ? !running
                    : (key_any || (op_q[3] && sense_any));

  // standby sequencer and gate flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_RUN;
      flag_q <= 1'b0;
      op_q <= 4'h0;
      wait_q <= 12'h000;
      rst_pulse_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      rst_pulse_q <= 1'b0;
      wake_q <= 1'b0;
      if (ctrl_wr && wmix[CTRL_FLAGCLR_BIT]) begin
        flag_q <= 1'b0;
      end
      case (state_q)
        ST_RUN: begin
          if (exec) begin
            op_q <= wmix[CTRL_OP_LSB +: 4];
            if (!legal || !pre_ok) begin
              rst_pulse_q <= 1'b1;
              flag_q <= 1'b0;
            end else if (flag_q) begin
              flag_q <= new_cond;
            end else if (new_cond) begin
              flag_q <= 1'b1;
            end else if (!is_stop) begin
              state_q <= ST_HALT;
            end else if (running || t9_q) begin
              state_q <= ST_PEND;
            end else begin
              state_q <= ST_STOP;
            end
          end
        end
        ST_PEND: begin
          if (!running && !t9_q) begin
            state_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (cond_now) begin
            state_q <= ST_WAIT;
            wait_q <= STOP_WAIT_LOAD;
          end
        end
        ST_WAIT: begin
          if (wait_q != 12'h000) begin
            wait_q <= wait_q - 12'h001;
          end else if (cond_now) begin
            state_q <= ST_RUN;
            flag_q <= 1'b1;
            wake_q <= 1'b1;
          end else begin
            state_q <= ST_STOP;
          end
        end
        ST_HALT: begin
          if (!running) begin
            state_q <= ST_RUN;
            flag_q <= 1'b1;
            wake_q <= 1'b1;
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // instruction-cycle tick, 64 or 128 clocks, held at zero while the oscillator is off
  assign tick = (tick_q == (cfg_q[CFG_DIV_BIT] ? TICK_LAST_SLOW : TICK_LAST_FAST));
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q == ST_STOP) begin
      tick_q <= 7'h00;
    end else begin
      tick_q <= tick ? 7'h00 : tick_q + 7'h01;
    end
  end

  // down counter and output enable; software writes only while the cpu runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= 9'h000;
      t9_q <= 1'b0;
      ir_hold_q <= 1'b0;
    end else if (rst_pulse_q || state_q == ST_STOP) begin
      count_q <= 9'h000;
      t9_q <= 1'b0;
      ir_hold_q <= 1'b0;
    end else if (tmr_wr) begin
      count_q <= wmix[8:0];
      t9_q <= wmix[TMR_T9_BIT];
      ir_hold_q <= wmix[TMR_T9_BIT] && (wmix[8:0] == 9'h000);
    end else begin
      if (running && tick) begin
        count_q <= count_q - 9'h001;
      end
      // a stalled stop request would never see the enable fall otherwise
      if (state_q == ST_PEND && !running) begin
        t9_q <= 1'b0;
      end
    end
  end

  // free carrier counter; starting mid-period only shortens the first high phase
  assign car_high = (car_q < car_len(cfg_q[CFG_CARMODE_LSB +: 2], cfg_q[CFG_DIV_BIT], 1'b1));
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q == ST_STOP) begin
      car_q <= 9'h000;
    end else if (car_q >= car_len(cfg_q[CFG_CARMODE_LSB +: 2], cfg_q[CFG_DIV_BIT], 1'b0) - 9'h001)
    begin
      car_q <= 9'h000;
    end else begin
      car_q <= car_q + 9'h001;
    end
  end

  // infrared and indicator outputs, carrier finishes its high phase after the count ends except in a pending stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      car_tail_q <= 1'b0;
      ir_q <= 1'b0;
      led_q <= 1'b1;
    end else begin
      car_tail_q <= running || (car_tail_q && car_high);
      ir_q <= ir_hold_q || (t9_q && (running || car_tail_q) &&
                            (cfg_q[CFG_CAROFF_BIT] || car_high));
      led_q <= !(t9_q && running);
    end
  end

  // oscillator pins and cpu hold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_run_q <= 1'b1;
      halt_q <= 1'b0;
    end else begin
      osc_run_q <= (state_q != ST_STOP);
      halt_q <= (state_q != ST_RUN);
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign scan_drive_pins_o = cfg_q[CFG_SCANVAL_LSB +: 8];
  assign scan_drive_pins_oe = {8{cfg_q[CFG_SCANOUT_BIT]}};
  assign sense1_indicator_pin_o = led_q;
  assign sense1_indicator_pin_oe = cfg_q[CFG_LEDMODE_BIT];
  assign ir_drive_pin = ir_q;
  assign osc_in_pin = osc_run_q;
  assign osc_out_pin = osc_run_q;
  assign cpu_halt = halt_q;
  assign core_reset_pulse = rst_pulse_q;
  assign wake_pulse = wake_q;

  // checks
  chk_stop_osc_low: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_STOP |=> !osc_in_pin && !osc_out_pin)
    else $error("oscillator pins not low in stop");
  chk_stop_count_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_STOP |-> count_q == 9'h000 && !t9_q)
    else $error("timer not cleared in stop");
  chk_wake_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(wake_pulse) |-> flag_q && state_q == ST_RUN)
    else $error("release without gate flag");
  chk_blocked_no_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && legal && pre_ok && (flag_q || new_cond)
    |=> state_q == ST_RUN && flag_q == $past(new_cond))
    else $error("standby entered with gate flag set");
  chk_bad_op_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && !(legal && pre_ok) |=> core_reset_pulse && state_q == ST_RUN)
    else $error("no internal reset on bad operand");
  chk_pend_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_PEND && running |=> state_q != ST_STOP)
    else $error("stop entered with timer running");
  chk_halt_release: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_HALT && !running |=> state_q == ST_RUN ##1 wake_pulse == 1'b0)
    else $error("halt not released at zero count");
  chk_tick_decrement: assert property (@(posedge aclk) disable iff (!aresetn)
    running && !tick && !tmr_wr && !rst_pulse_q |=> count_q == $past(count_q))
    else $error("counter moved off tick");
  chk_wait_lapse: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_WAIT && wait_q == 12'h000 && !cond_now |=> state_q == ST_STOP)
    else $error("no return to stop after lapsed release");
  chk_static_high: assert property (@(posedge aclk) disable iff (!aresetn)
    ir_hold_q |=> ir_drive_pin)
    else $error("infrared not high on static write");
  cov_stop_entry: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_RUN ##1 state_q == ST_STOP);
  cov_stop_wake: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_WAIT ##1 state_q == ST_RUN);
  cov_halt_wake: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_HALT ##1 state_q == ST_RUN);
  cov_reenter: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_WAIT ##1 state_q == ST_STOP);
endmodule

// >>> sim/key_sense_model.sv
// key matrix and sense switch model on the far side of the standby block
`timescale 1ns/1ps
module key_sense_model (
  input wire logic [7:0] scan_drive_pins_o,
  input wire logic [7:0] scan_drive_pins_oe,
  input wire logic sense1_indicator_pin_o,
  input wire logic sense1_indicator_pin_oe,
  input wire logic press_en,
  input wire logic [2:0] press_scan,
  input wire logic [1:0] press_key,
  input wire logic s0_closed,
  input wire logic s1_closed,
  output logic [3:0] key_input_pins,
  output logic sense0_pin,
  output logic sense1_indicator_pin_i
);
  // a closed key ties one scan line to one key input; pull-downs hold open inputs low
  always_comb begin
    key_input_pins = 4'h0;
    if (press_en && scan_drive_pins_oe[press_scan]) begin
      key_input_pins[press_key] = scan_drive_pins_o[press_scan];
    end
  end
  // switches pull high when closed, pulled down when open
  assign sense0_pin = s0_closed;
  // indicator drive wins on the shared pin, so only input mode can release
  assign sense1_indicator_pin_i = sense1_indicator_pin_oe ? sense1_indicator_pin_o
                                  : s1_closed;
endmodule

// >>> sim/standby_halt_control_bench.sv
// self-checking bench for the standby sequencer, timer output and register slave
`timescale 1ns/1ps
module standby_halt_control_bench import standby_pkg::*;;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, scan_o, scan_oe;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, keys;
  logic [1:0] bresp, rresp, press_key;
  logic s0, s1_i, s1_o, s1_oe, ir, osc_i, osc_o, halt, rst_p, wake_p;
  logic press_en, s0_closed, s1_closed;
  logic [2:0] press_scan;
  int miscompares, n_compared, n_wake, n_rst, now;

  standby_halt_control dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .key_input_pins(keys), .scan_drive_pins_o(scan_o), .scan_drive_pins_oe(scan_oe),
    .sense0_pin(s0), .sense1_indicator_pin_i(s1_i), .sense1_indicator_pin_o(s1_o),
    .sense1_indicator_pin_oe(s1_oe), .ir_drive_pin(ir), .osc_in_pin(osc_i),
    .osc_out_pin(osc_o), .cpu_halt(halt), .core_reset_pulse(rst_p), .wake_pulse(wake_p));

  key_sense_model far_side (.scan_drive_pins_o(scan_o), .scan_drive_pins_oe(scan_oe),
    .sense1_indicator_pin_o(s1_o), .sense1_indicator_pin_oe(s1_oe), .press_en(press_en),
    .press_scan(press_scan), .press_key(press_key), .s0_closed(s0_closed),
    .s1_closed(s1_closed), .key_input_pins(keys), .sense0_pin(s0),
    .sense1_indicator_pin_i(s1_i));

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // pulses are one cycle wide, so count them as they pass
  always @(posedge aclk) begin
    now++;
    if (wake_p === 1'b1) n_wake++;
    if (rst_p === 1'b1) n_rst++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic timed_out(input string what);
    miscompares++;
    $display("CHECK FAILED %s expected answer seen timeout", what);
    report_and_stop();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // write: address and data offered together, bready held until the response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        check("write resp", bresp, RESP_OKAY);
        bready <= 1'b0;
        break;
      end
      if (n > 50) timed_out("write response");
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
      if (n > 50) timed_out("read data");
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(what, d, exp);
  endtask

  // state field and gate flag of the status word
  task automatic st_chk(input string what, input logic [4:0] st, input logic fl);
    logic [31:0] d;
    logic [1:0] r;
    rd(OFS_STATUS, d, r);
    check(what, {26'h0, d[5:0]}, {26'h0, st, fl});
  endtask

  // key contacts settle after the two-flop input synchroniser
  task automatic key(input logic on, input logic [2:0] sc, input logic [1:0] k);
    @(posedge aclk);
    press_en <= on;
    press_scan <= sc;
    press_key <= k;
    cyc(4);
  endtask

  task automatic wait_wake(input int lim);
    int w0;
    int n;
    w0 = n_wake;
    n = 0;
    while (n_wake == w0) begin
      @(posedge aclk);
      n++;
      if (n > lim) timed_out("wake pulse");
    end
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rd_chk(OFS_CONFIG, CFG_RESET, "config reset value");
    st_chk("status after reset", ST_RUN, 1'b0);
    check("osc pins running", {osc_i, osc_o}, 2'b11);
    check("scan and indicator drive", {scan_oe, scan_o, s1_oe}, 17'h1FFFF);
    rd(8'h10, d, r);
    check("unmapped resp", r, RESP_SLVERR);
    check("unmapped data", d, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_ir();
    wr(OFS_TIMER, 32'h200);
    cyc(1);
    check("ir high", ir, 1'b1);
    wr(OFS_TIMER, 32'h0);
    cyc(1);
    check("ir low after short pulse", ir, 1'b0);
    $display("ir pulse test done");
  endtask

  task automatic t_halt();
    int t0;
    wr(OFS_CONFIG, 32'h0001_FF27); // carrier off so ir is a plain level
    wr(OFS_TIMER, 32'h205);
    t0 = now;
    wr(OFS_CTRL, 32'h105);
    cyc(2);
    st_chk("halt entered", ST_HALT, 1'b0);
    check("cpu halted", halt, 1'b1);
    check("osc in halt", {osc_i, osc_o}, 2'b11);
    check("ir in halt", ir, 1'b1);
    check("indicator in halt", s1_o, 1'b0);
    wait_wake(600);
    check("halt length", (now - t0 >= 250) && (now - t0 <= 400), 1'b1);
    st_chk("halt released", ST_RUN, 1'b1);
    check("cpu resumed", halt, 1'b0);
    rd_chk(OFS_CONFIG, 32'h0001_FF27, "config kept");
    $display("halt test done");
  endtask

  // carrier on at half rate: high 8 of every 16 clocks, ticks every 128
  task automatic t_carrier();
    int t0;
    int hi;
    wr(OFS_CONFIG, 32'h0001_FF28);
    wr(OFS_TIMER, 32'h203);
    t0 = now;
    cyc(20);
    hi = 0;
    repeat (32) begin
      @(posedge aclk);
      hi += ir;
    end
    check("carrier high count", hi, 16);
    check("indicator while running", s1_o, 1'b0);
    while (s1_o !== 1'b1) begin
      @(posedge aclk);
      if (now - t0 > 600) timed_out("timer end");
    end
    check("slow tick length", (now - t0 >= 250) && (now - t0 <= 400), 1'b1);
    cyc(40);
    check("ir low after carrier", ir, 1'b0);
    $display("carrier test done");
  endtask

  task automatic t_flag();
    int r0;
    r0 = n_rst;
    wr(OFS_CTRL, 32'h105); // counter already zero: release holds
    st_chk("flag kept", ST_RUN, 1'b1);
    wr(OFS_CTRL, 32'h100); // no key closed
    st_chk("flag cleared", ST_RUN, 1'b0);
    check("no internal reset", n_rst, r0);
    key(1'b1, 3'd2, 2'd0);
    wr(OFS_CTRL, 32'h100);
    st_chk("release already true", ST_RUN, 1'b1);
    key(1'b0, 3'd2, 2'd0);
    wr(OFS_CTRL, 32'h200); // software clears the gate flag
    $display("gate flag test done");
  endtask

  task automatic t_stop();
    int t0;
    wr(OFS_CTRL, 32'h103);
    cyc(2);
    st_chk("stop entered", ST_STOP, 1'b0);
    check("osc stopped", {osc_i, osc_o}, 2'b00);
    key(1'b1, 3'd5, 2'd3);
    cyc(40);
    key(1'b0, 3'd5, 2'd3);
    cyc(450);
    st_chk("stop re-entered", ST_STOP, 1'b0);
    t0 = now;
    key(1'b1, 3'd7, 2'd1); // held longer than the wait
    wait_wake(600);
    check("wait length", (now - t0 >= 400) && (now - t0 <= 420), 1'b1);
    // first access after a stop release is a plain read, never a command
    st_chk("stop released", ST_RUN, 1'b1);
    check("osc restarted", {osc_i, osc_o}, 2'b11);
    key(1'b0, 3'd7, 2'd1);
    wr(OFS_CTRL, 32'h200);
    $display("stop test done");
  endtask

  task automatic t_sense();
    wr(OFS_CONFIG, 32'h0001_FF37); // sense 0 as input
    wr(OFS_CTRL, 32'h108);
    cyc(2);
    st_chk("stop with sense", ST_STOP, 1'b0);
    s0_closed <= 1'b1;
    wait_wake(600);
    st_chk("sense release", ST_RUN, 1'b1);
    s0_closed <= 1'b0;
    wr(OFS_CTRL, 32'h200);
    $display("sense test done");
  endtask

  task automatic t_pend();
    wr(OFS_TIMER, 32'h205);
    wr(OFS_CTRL, 32'h100);
    cyc(2);
    st_chk("stop pending", ST_PEND, 1'b0);
    cyc(450);
    st_chk("stop after count", ST_STOP, 1'b0);
    rd_chk(OFS_TIMER, 32'h0, "timer in stop");
    @(posedge aclk);
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    cyc(2);
    st_chk("reset release", ST_RUN, 1'b0);
    check("osc after reset", {osc_i, osc_o, halt}, 3'b110);
    $display("pending stop test done");
  endtask

  task automatic t_illegal();
    int r0;
    r0 = n_rst;
    wr(OFS_CTRL, 32'h101);
    cyc(3);
    check("illegal operand", n_rst, r0 + 1);
    wr(OFS_CONFIG, 32'h0001_7F23); // one scan line low
    wr(OFS_CTRL, 32'h100);
    cyc(3);
    check("unmet precondition", n_rst, r0 + 2);
    wr(OFS_CTRL, 32'h106); // only scan line 0 must be high
    cyc(2);
    st_chk("stop on line 0", ST_STOP, 1'b0);
    key(1'b1, 3'd0, 2'd2);
    wait_wake(600);
    st_chk("line 0 release", ST_RUN, 1'b1);
    key(1'b0, 3'd0, 2'd2);
    $display("illegal operand test done");
  endtask

  // reset for five cycles, then the scenarios in turn
  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {press_en, press_scan, press_key, s0_closed, s1_closed} = '0;
    cyc(5);
    aresetn <= 1'b1;
    t_reset();
    t_ir();
    t_halt();
    t_carrier();
    t_flag();
    t_stop();
    t_sense();
    t_pend();
    t_illegal();
    report_and_stop();
  end
endmodule
